// ==== logic/fault_sup_pkg.sv ====
// Shared constants for the protection fault supervisor.
package fault_sup_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 40;
  localparam int unsigned NS_PER_US        = 1000;
  localparam int unsigned US_PER_MS        = 1000;
  localparam int unsigned OVP_BLANK_US     = 10;
  localparam int unsigned OLP_BLANK_MS     = 30;
  localparam int unsigned ZC_BLANK_US      = 100;
  localparam int unsigned SW_BLANK_NS      = 190;
  localparam int unsigned MAX_ON_US        = 30;
  // Least times: round up to whole cycles.
  localparam int unsigned OVP_BLANK_CYC = OVP_BLANK_US * CLK_MHZ;
  localparam int unsigned OLP_BLANK_CYC = OLP_BLANK_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned ZC_BLANK_CYC  = ZC_BLANK_US * CLK_MHZ;
  localparam int unsigned SW_BLANK_CYC  =
    (SW_BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int unsigned MAX_ON_CYC    = MAX_ON_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_EVT_STATUS = 5'h00;
  localparam logic [4:0] REG_EVT_CLEAR  = 5'h04;
  localparam logic [4:0] REG_EVT_ENABLE = 5'h08;
  localparam logic [4:0] REG_CONTROL    = 5'h0c;
  localparam logic [4:0] REG_STATE      = 5'h10;
  localparam int unsigned EVT_W         = 7;
  localparam int unsigned EVT_OVP       = 0;
  localparam int unsigned EVT_UV        = 1;
  localparam int unsigned EVT_OLP       = 2;
  localparam int unsigned EVT_OTP       = 3;
  localparam int unsigned EVT_ZC        = 4;
  localparam int unsigned EVT_SW        = 5;
  localparam int unsigned EVT_MAXON     = 6;
  localparam int unsigned CTL_HOLD      = 0;
  localparam logic [EVT_W-1:0] EVT_ENABLE_RST = 7'h00;
  localparam logic            CTL_HOLD_RST   = 1'b0;

  // ----------------------------------------------------------------
  // Pin input indices
  // ----------------------------------------------------------------
  localparam int unsigned PIN_N     = 10;
  localparam int unsigned PIN_OVP   = 0;
  localparam int unsigned PIN_UV    = 1;
  localparam int unsigned PIN_PD    = 2;
  localparam int unsigned PIN_ON    = 3;
  localparam int unsigned PIN_OLP   = 4;
  localparam int unsigned PIN_ZC    = 5;
  localparam int unsigned PIN_SW    = 6;
  localparam int unsigned PIN_OTP   = 7;
  localparam int unsigned PIN_GATE  = 8;
  localparam int unsigned PIN_BURST = 9;

  typedef enum logic [3:0] {
    ST_CHARGE = 4'b0001,
    ST_RUN    = 4'b0010,
    ST_AUTO   = 4'b0100,
    ST_LATCH  = 4'b1000
  } mode_e;

endpackage : fault_sup_pkg

// ==== logic/flag_blanker.sv ====
// Blanking counter that fires after uninterrupted assertion of a flag.
`timescale 1ns/1ps
module flag_blanker #(
  parameter int unsigned LIMIT = 8,
  parameter int unsigned W     = $clog2(LIMIT + 1)
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic flag,
  input  wire logic enable,
  output logic      fired
);

  localparam logic [W-1:0] LIMIT_W = W'(LIMIT);
  localparam logic [W-1:0] ONE_W   = W'(1);

  logic [W-1:0] cnt_r;

  if (LIMIT < 1) begin : g_bad_limit
    $error("flag_blanker: LIMIT must be at least one cycle");
  end

  if (W < $clog2(LIMIT + 1)) begin : g_bad_width
    $error("flag_blanker: W is too narrow to hold LIMIT");
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Any gap in the qualified flag restarts the interval from zero.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (!(flag && enable)) begin
      cnt_r <= '0;
    end else if (cnt_r != LIMIT_W) begin
      cnt_r <= cnt_r + ONE_W;
    end
  end

  assign fired = (cnt_r == LIMIT_W);

endmodule : flag_blanker

// ==== logic/protection_fault_supervisor.sv ====
// Fault supervisor: flag blanking, auto-restart and latch-off sequencing.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Supply overvoltage held for 10 us outside burst mode puts the device in auto-restart.
// - Supply undervoltage in run or auto-restart resets the control state to charging and keeps the switch off.
// - Below turn-off the startup cell charges the supply, and above turn-on a soft-start begins.
// - Feedback overload held for 30 ms causes auto-restart, shorter pulses are tolerated.
// - Feedback overload and its blanking timer are ignored while burst mode is active.
// - Zero-crossing overvoltage is sampled only with the switch off and latches after 100 us.
// - Latch-off is left only when the supply drops below the power-down threshold.
// - Over-temperature causes auto-restart except while burst mode is active.
// - Short-winding current held for 190 ns during on-time causes latch-off.
// - Short-winding detection is suppressed whenever burst mode is active.
// - In latch-off the startup cell charges from the turn-off to the turn-on threshold, forever.
// - A gate held high beyond the maximum on-time is turned off at once.
// - The maximum on-time limit is 30 us.
module protection_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int unsigned OLP_CYCLES = OLP_BLANK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        supply_ovp_flag,
  input  wire logic        supply_uv_flag,
  input  wire logic        supply_powerdown_flag,
  input  wire logic        supply_above_turnon_flag,
  input  wire logic        feedback_overload_flag,
  input  wire logic        zero_crossing_ovp_flag,
  input  wire logic        short_winding_flag,
  input  wire logic        over_temp_flag,
  input  wire logic        gate_state,
  input  wire logic        burst_active,
  output logic             gate_enable,
  output logic             startup_cell_en,
  output logic             soft_start,
  output logic             irq,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  if (OLP_CYCLES < 1) begin : g_bad_olp
    $error("protection_fault_supervisor: OLP_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync1_r;
  logic [PIN_N-1:0] sync2_r;
  logic [PIN_N-1:0] sync3_r;
  logic [PIN_N-1:0] pin_f_r;

  assign pin_raw = {burst_active, gate_state, over_temp_flag, short_winding_flag,
                    zero_crossing_ovp_flag, feedback_overload_flag,
                    supply_above_turnon_flag, supply_powerdown_flag,
                    supply_uv_flag, supply_ovp_flag};

  // The filtered copy only moves when the second and third stages agree,
  // which hides a metastable settle in the second stage.
  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        sync1_r[i] <= 1'b0;
        sync2_r[i] <= 1'b0;
        sync3_r[i] <= 1'b0;
        pin_f_r[i] <= 1'b0;
      end else begin
        sync1_r[i] <= pin_raw[i];
        sync2_r[i] <= sync1_r[i];
        sync3_r[i] <= sync2_r[i];
        if (sync2_r[i] == sync3_r[i]) begin
          pin_f_r[i] <= sync3_r[i];
        end
      end
    end
  end

  logic ovp_f, uv_f, pd_f, on_f, olp_f, zc_f, sw_f, otp_f, gate_f, burst_f;
  assign ovp_f   = pin_f_r[PIN_OVP];
  assign uv_f    = pin_f_r[PIN_UV];
  assign pd_f    = pin_f_r[PIN_PD];
  assign on_f    = pin_f_r[PIN_ON];
  assign olp_f   = pin_f_r[PIN_OLP];
  assign zc_f    = pin_f_r[PIN_ZC];
  assign sw_f    = pin_f_r[PIN_SW];
  assign otp_f   = pin_f_r[PIN_OTP];
  assign gate_f  = pin_f_r[PIN_GATE];
  assign burst_f = pin_f_r[PIN_BURST];

  // ----------------------------------------------------------------
  // Blanking timers
  // ----------------------------------------------------------------
  logic ovp_fire, olp_fire, zc_fire, sw_fire, maxon_fire;

  flag_blanker #(.LIMIT(OVP_BLANK_CYC)) u_ovp_blank (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .flag     (ovp_f),
    .enable   (!burst_f),
    .fired    (ovp_fire)
  );

  flag_blanker #(.LIMIT(OLP_CYCLES)) u_olp_blank (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .flag     (olp_f),
    .enable   (!burst_f),
    .fired    (olp_fire)
  );

  flag_blanker #(.LIMIT(ZC_BLANK_CYC)) u_zc_blank (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .flag     (zc_f),
    .enable   (!gate_f),
    .fired    (zc_fire)
  );

  flag_blanker #(.LIMIT(SW_BLANK_CYC)) u_sw_blank (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .flag     (sw_f),
    .enable   (gate_f && !burst_f),
    .fired    (sw_fire)
  );

  flag_blanker #(.LIMIT(MAX_ON_CYC)) u_maxon_blank (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .flag     (gate_f),
    .enable   (1'b1),
    .fired    (maxon_fire)
  );

  logic latch_trip, auto_trip, otp_trip;
  assign otp_trip   = otp_f && !burst_f;
  assign latch_trip = zc_fire || sw_fire;
  assign auto_trip  = ovp_fire || olp_fire || otp_trip;

  // ----------------------------------------------------------------
  // Protection mode sequencer
  // ----------------------------------------------------------------
  mode_e mode_r;
  mode_e mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      ST_CHARGE: begin
        if (on_f) begin
          mode_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (latch_trip) begin
          mode_nxt = ST_LATCH;
        end else if (uv_f) begin
          mode_nxt = ST_CHARGE;
        end else if (auto_trip) begin
          mode_nxt = ST_AUTO;
        end
      end
      ST_AUTO: begin
        if (uv_f) begin
          mode_nxt = ST_CHARGE;
        end
      end
      ST_LATCH: begin
        // Nothing but a supply collapse releases the latch.
        if (pd_f) begin
          mode_nxt = ST_CHARGE;
        end
      end
      default: mode_nxt = ST_CHARGE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= ST_CHARGE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_start <= 1'b0;
    end else begin
      soft_start <= (mode_r == ST_CHARGE) && (mode_nxt == ST_RUN);
    end
  end

  // In latch-off the cell runs as a hysteretic charger between the two
  // supply thresholds, so the latch survives while the supply is kept up.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      startup_cell_en <= 1'b1;
    end else begin
      unique case (mode_nxt)
        ST_CHARGE: startup_cell_en <= 1'b1;
        ST_LATCH: begin
          if (uv_f) begin
            startup_cell_en <= 1'b1;
          end else if (on_f) begin
            startup_cell_en <= 1'b0;
          end
        end
        default: startup_cell_en <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Gate permission
  // ----------------------------------------------------------------
  logic ctl_hold_r;
  logic maxon_kill_r;

  // The kill holds until the driver reports the gate low, so a stuck
  // request cannot re-enable the switch the cycle after the limit.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      maxon_kill_r <= 1'b0;
    end else if (maxon_fire) begin
      maxon_kill_r <= 1'b1;
    end else if (!gate_f) begin
      maxon_kill_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_enable <= 1'b0;
    end else begin
      gate_enable <= (mode_r == ST_RUN) && !ctl_hold_r && !maxon_fire
                     && !maxon_kill_r;
    end
  end

  // ----------------------------------------------------------------
  // Event status and interrupt
  // ----------------------------------------------------------------
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_status_r;
  logic [EVT_W-1:0] evt_enable_r;
  logic [EVT_W-1:0] evt_clear;

  always_comb begin
    evt_set             = '0;
    evt_set[EVT_OVP]    = ovp_fire;
    evt_set[EVT_UV]     = uv_f && (mode_r != ST_CHARGE);
    evt_set[EVT_OLP]    = olp_fire;
    evt_set[EVT_OTP]    = otp_trip;
    evt_set[EVT_ZC]     = zc_fire;
    evt_set[EVT_SW]     = sw_fire;
    evt_set[EVT_MAXON]  = maxon_fire;
  end

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_status_r <= '0;
    end else begin
      evt_status_r <= (evt_status_r & ~evt_clear) | evt_set;
    end
  end

  assign irq = |(evt_status_r & evt_enable_r);

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait state on every access keeps read data registered.
  logic ack_r;
  logic bus_req;
  logic wr_take;
  logic rd_take;

  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_r;
  assign wr_take         = avs_write && ack_r;
  assign rd_take         = avs_read && !ack_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req && !ack_r;
    end
  end

  assign evt_clear = (wr_take && avs_address == REG_EVT_CLEAR && avs_byteenable[0])
                     ? avs_writedata[EVT_W-1:0] : '0;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_enable_r <= EVT_ENABLE_RST;
    end else if (wr_take && avs_address == REG_EVT_ENABLE && avs_byteenable[0]) begin
      evt_enable_r <= avs_writedata[EVT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_hold_r <= CTL_HOLD_RST;
    end else if (wr_take && avs_address == REG_CONTROL && avs_byteenable[0]) begin
      ctl_hold_r <= avs_writedata[CTL_HOLD];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      unique case (avs_address)
        REG_EVT_STATUS: avs_readdata <= {25'h0000000, evt_status_r};
        REG_EVT_ENABLE: avs_readdata <= {25'h0000000, evt_enable_r};
        REG_CONTROL:    avs_readdata <= {31'h00000000, ctl_hold_r};
        REG_STATE:      avs_readdata <= {25'h0000000, burst_f, startup_cell_en,
                                         gate_enable, mode_r};
        default:        avs_readdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [21:0] olp_hold_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      olp_hold_r <= '0;
    end else if (olp_f && !burst_f) begin
      olp_hold_r <= olp_hold_r + 22'h000001;
    end else begin
      olp_hold_r <= '0;
    end
  end

  AST_OVP_RESTART: assert property (
    mode_r == ST_RUN && ovp_fire && !latch_trip && !uv_f |=> mode_r == ST_AUTO)
    else $error("overvoltage did not start auto-restart");
  AST_UV_RESET: assert property (
    uv_f && mode_r inside {ST_RUN, ST_AUTO} && !latch_trip
    |=> mode_r == ST_CHARGE ##1 !gate_enable)
    else $error("undervoltage did not reset the control state");
  AST_SOFT_START: assert property (
    mode_r == ST_CHARGE && on_f |=> mode_r == ST_RUN && soft_start ##1 !soft_start)
    else $error("restart without a single soft-start pulse");
  AST_OLP_BLANK: assert property (
    $rose(olp_fire) |-> olp_hold_r == 22'(OLP_CYCLES))
    else $error("overload fired before its full blanking time");
  AST_OLP_BURST: assert property (
    burst_f |=> !olp_fire)
    else $error("overload timer ran in burst mode");
  AST_ZC_OFF_ONLY: assert property (
    $rose(zc_fire) |-> $past(!gate_f && zc_f, 1) && $past(!gate_f && zc_f, 8))
    else $error("zero-crossing overvoltage sampled during on-time");
  AST_LATCH_HOLD: assert property (
    mode_r == ST_LATCH && !pd_f |=> mode_r == ST_LATCH)
    else $error("latch-off released without power-down");
  AST_OTP_RESTART: assert property (
    mode_r == ST_RUN && otp_f && !burst_f && !latch_trip && !uv_f |=> mode_r == ST_AUTO)
    else $error("over-temperature did not start auto-restart");
  AST_SW_BLANK: assert property (
    $rose(sw_fire) |-> $past(sw_f && gate_f, 1) && $past(sw_f && gate_f, 8))
    else $error("short-winding fired without its blanking time");
  AST_SW_BURST: assert property (
    burst_f |=> !sw_fire)
    else $error("short-winding detection active in burst mode");
  AST_LATCH_CHARGE: assert property (
    mode_r == ST_LATCH && uv_f && !pd_f |=> startup_cell_en)
    else $error("startup cell not enabled in latch-off");
  AST_MAXON_OFF: assert property (
    maxon_fire |=> !gate_enable [*2])
    else $error("gate not removed at the maximum on-time");
  AST_LATCH_PRIO: assert property (
    mode_r == ST_RUN && latch_trip |=> mode_r == ST_LATCH ##1 !gate_enable)
    else $error("latch-off lost priority over auto-restart");

  COV_AUTO_CYCLE: cover property (
    mode_r == ST_AUTO ##[1:1000] mode_r == ST_CHARGE ##[1:1000] soft_start);
  COV_LATCH_RECHARGE: cover property (
    mode_r == ST_LATCH && $rose(startup_cell_en));
  COV_MAXON_KILL: cover property (maxon_fire && mode_r == ST_RUN);
  COV_IRQ: cover property ($rose(irq));

endmodule : protection_fault_supervisor

// ==== verif/supply_model.sv ====
// Supply rail, startup cell, comparator and gate driver model.
`timescale 1ns/1ps
module supply_model #(
  parameter int PD_DV = 60
) (
  input  wire logic core_clk,
  input  wire logic startup_cell_en,
  input  wire logic gate_enable,
  input  wire logic pwm_req,
  input  wire logic drain,
  input  wire logic surge,
  output logic      ovp,
  output logic      uv,
  output logic      pd,
  output logic      on,
  output logic      gate_state
);
  // ----------------------------------------------------------------
  // Supply in tenths of a volt
  // ----------------------------------------------------------------
  // Load drain wins over charging so the rail can always be pulled down.
  int supply_dv = 0;
  always @(posedge core_clk) begin
    if (drain && supply_dv > 0) begin
      supply_dv <= supply_dv - 1;
    end else if ((startup_cell_en || surge) && supply_dv < 260) begin
      supply_dv <= supply_dv + 1;
    end
  end
  assign ovp        = supply_dv > 250;
  assign uv         = supply_dv < 105;
  assign pd         = supply_dv < PD_DV;
  assign on         = supply_dv >= 180;
  assign gate_state = gate_enable & pwm_req;
endmodule : supply_model

// ==== verif/testbench.sv ====
// Self-checking testbench for the protection fault supervisor.
`timescale 1ns/1ps
module testbench;
  import fault_sup_pkg::*;
  localparam int OLP_N = 50;
  logic        core_clk = 0;
  logic        arst_n   = 0;
  logic        drain    = 0;
  logic        surge    = 0;
  logic        pwm_req  = 0;
  logic        olp      = 0;
  logic        zc       = 0;
  logic        sw       = 0;
  logic        otp      = 0;
  logic        burst    = 0;
  logic        rd       = 0;
  logic        wr       = 0;
  logic [4:0]  adr      = '0;
  logic [31:0] wdat     = '0;
  logic        ovp, uv, pd, on, gate_state, gate_enable, startup_cell_en, soft_start, irq;
  logic        wait_req;
  logic [31:0] rdat, got;
  int          fails = 0, total_checks = 0, cyc = 0, ss_cnt = 0;

  always #12.5 core_clk = ~core_clk;

  supply_model i_supply_model (.core_clk(core_clk), .startup_cell_en(startup_cell_en),
    .gate_enable(gate_enable), .pwm_req(pwm_req), .drain(drain), .surge(surge),
    .ovp(ovp), .uv(uv), .pd(pd), .on(on), .gate_state(gate_state));

  protection_fault_supervisor #(.OLP_CYCLES(OLP_N)) i_protection_fault_supervisor (
    .core_clk(core_clk), .arst_n(arst_n), .supply_ovp_flag(ovp), .supply_uv_flag(uv),
    .supply_powerdown_flag(pd), .supply_above_turnon_flag(on),
    .feedback_overload_flag(olp), .zero_crossing_ovp_flag(zc), .short_winding_flag(sw),
    .over_temp_flag(otp), .gate_state(gate_state), .burst_active(burst),
    .gate_enable(gate_enable), .startup_cell_en(startup_cell_en), .soft_start(soft_start),
    .irq(irq), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wait_req));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The ceiling is about three times the expected run length.
  always @(posedge core_clk) begin
    cyc++;
    if (soft_start === 1'b1) ss_cnt++;
    if (cyc == 45000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    total_checks++;
    if (act !== exp) begin
      fails++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, act);
    end
  endtask : check

  // The request is held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    rd   <= !w;
    wr   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge core_clk); while (wait_req !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wait_mode(input logic [3:0] m, input int lim);
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STATE, '0);
      n++;
    end while (got[3:0] !== m && n < lim);
    check({28'h0, got[3:0]}, {28'h0, m});
  endtask : wait_mode

  localparam int SIG_PD   = 0;
  localparam int SIG_CELL = 1;
  localparam int SIG_GATE = 2;

  function automatic logic pick(input int s);
    case (s)
      SIG_PD:   return pd;
      SIG_CELL: return startup_cell_en;
      default:  return gate_enable;
    endcase
  endfunction : pick

  task automatic wait_bit(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, pick(s)}, {31'h0, v});
  endtask : wait_bit

  // The drain is held past the power-down crossing so that the level
  // outlasts the input filter before the cell starts charging again.
  task automatic restart();
    drain <= 1'b1;
    wait_bit(SIG_PD, 1'b1, 400);
    check({31'h0, gate_enable}, 32'h0);
    repeat (8) @(posedge core_clk);
    drain <= 1'b0;
    wait_mode(ST_RUN, 200);
  endtask : restart

  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    check({31'h0, startup_cell_en}, 32'h1);
    bus(1'b0, REG_EVT_ENABLE, '0);
    check(got, {25'h0, EVT_ENABLE_RST});
    bus(1'b0, 5'h1c, '0);
    check(got, 32'h0);
    wait_mode(ST_RUN, 200);
    check(ss_cnt, 1);
    check({30'h0, startup_cell_en, gate_enable}, 32'h1);
    $display("test startup done");

    bus(1'b1, REG_EVT_ENABLE, 32'h1 << EVT_SW);
    burst   <= 1'b1;
    pwm_req <= 1'b1;
    sw      <= 1'b1;
    repeat (50) @(posedge core_clk);
    wait_mode(ST_RUN, 1);
    burst <= 1'b0;
    wait_mode(ST_LATCH, 20);
    check({31'h0, gate_enable}, 32'h0);
    check({31'h0, irq}, 32'h1);
    sw      <= 1'b0;
    pwm_req <= 1'b0;
    bus(1'b1, REG_EVT_ENABLE, '0);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, REG_EVT_CLEAR, 32'h1 << EVT_SW);
    bus(1'b0, REG_EVT_STATUS, '0);
    check({31'h0, got[EVT_SW]}, 32'h0);
    drain <= 1'b1;
    wait_bit(SIG_CELL, 1'b1, 300);
    drain <= 1'b0;
    wait_bit(SIG_CELL, 1'b0, 300);
    wait_mode(ST_LATCH, 1);
    restart();
    $display("test latch done");

    burst <= 1'b1;
    olp   <= 1'b1;
    repeat (OLP_N + 20) @(posedge core_clk);
    wait_mode(ST_RUN, 1);
    burst <= 1'b0;
    olp   <= 1'b0;
    repeat (5) @(posedge core_clk);
    olp <= 1'b1;
    repeat (OLP_N - 10) @(posedge core_clk);
    olp <= 1'b0;
    repeat (10) @(posedge core_clk);
    wait_mode(ST_RUN, 1);
    olp <= 1'b1;
    wait_mode(ST_AUTO, 40);
    check({31'h0, gate_enable}, 32'h0);
    olp <= 1'b0;
    restart();
    $display("test overload done");

    burst <= 1'b1;
    otp   <= 1'b1;
    repeat (20) @(posedge core_clk);
    wait_mode(ST_RUN, 1);
    burst <= 1'b0;
    wait_mode(ST_AUTO, 10);
    otp <= 1'b0;
    restart();
    surge <= 1'b1;
    wait_mode(ST_AUTO, 300);
    surge <= 1'b0;
    restart();
    $display("test auto restart done");

    // The flag stays up far past its blanking time, but every off-time
    // window is short, so only on-time sampling would latch here.
    zc <= 1'b1;
    repeat (8) begin
      pwm_req <= 1'b1;
      repeat (600) @(posedge core_clk);
      pwm_req <= 1'b0;
      repeat (100) @(posedge core_clk);
    end
    wait_mode(ST_RUN, 1);
    repeat (ZC_BLANK_CYC - 1000) @(posedge core_clk);
    wait_mode(ST_RUN, 1);
    wait_mode(ST_LATCH, 600);
    zc <= 1'b0;
    restart();
    pwm_req <= 1'b1;
    repeat (MAX_ON_CYC - 10) @(posedge core_clk);
    check({31'h0, gate_enable}, 32'h1);
    wait_bit(SIG_GATE, 1'b0, 30);
    pwm_req <= 1'b0;
    wait_bit(SIG_GATE, 1'b1, 30);
    $display("test timing done");
    end_sim();
  end
endmodule : testbench
